// ---- common/qbx_defines.svh ----
// Timing counts, address fields and constants for the port expander controller
`ifndef QBX_DEFINES_SVH
`define QBX_DEFINES_SVH
`define QBX_CLK_MHZ        200
`define QBX_HALF_NS        2500
`define QBX_HALF_CYC       ((`QBX_HALF_NS * `QBX_CLK_MHZ) / 1000)
`define QBX_QTR_CYC        (`QBX_HALF_CYC / 2)
`define QBX_ADDR_NIBBLE    4'h4
`define QBX_DIR_READ       1'b1
`define QBX_DIR_WRITE      1'b0
`define QBX_PORT_RESET     8'hFF
`define QBX_HALF_W         10
`endif

// ---- common/qbx_pkg.sv ----
// Types for the port expander controller
package qbx_pkg;
  typedef enum logic [3:0] {
    QBX_IDLE, QBX_START, QBX_BIT_LO, QBX_BIT_HI, QBX_ACK_LO, QBX_ACK_HI,
    QBX_STOP_LO, QBX_STOP_HI, QBX_STOP_END
  } qbx_state_t;
  typedef enum logic [1:0] {QBX_PH_ADDR, QBX_PH_WDATA, QBX_PH_RDATA} qbx_phase_t;
  typedef struct packed {
    qbx_state_t state;
    qbx_phase_t phase;
    logic [9:0] tick;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic [7:0] rdata;
    logic       busy;
    logic       done;
    logic       nack;
    logic       scl_oe;
    logic       irq_pend;
    logic       sda_oe;
    logic       dir;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] irq_s;
  } qbx_regs_t;
endpackage

// ---- core/qbx_ctrl.sv ----
// I2C controller that writes and reads a quasi-bidirectional port expander
`timescale 1ns/1ps
`default_nettype none
`include "qbx_defines.svh"
module qbx_ctrl
  import qbx_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // User command port
  input  wire logic       req,
  input  wire logic       req_read,
  input  wire logic [2:0] addr_select,
  input  wire logic [7:0] wdata,
  output var  logic       busy,
  output var  logic       done,
  output var  logic       nack,
  output var  logic [7:0] rdata,
  output var  logic       irq_pending,
  // I2C pins, open drain: oe high pulls the line low
  input  wire logic       scl_line,
  output var  logic       scl_oe,
  input  wire logic       sda_line,
  output var  logic       sda_oe,
  // Expander interrupt pin, active low
  input  wire logic       irq_n
);
  qbx_regs_t r;
  qbx_regs_t next_r;

  // Address byte: fixed nibble, selects, direction last
  function automatic logic [7:0] addr_byte(input logic [2:0] sel, input logic rd);
    addr_byte = {`QBX_ADDR_NIBBLE, sel, rd};
  endfunction

  wire logic half_done = (r.tick == 10'(`QBX_HALF_CYC - 1));
  // Apart from the start and stop themselves, SDA only moves mid way through SCL low, so a target never sees a false start or stop
  wire logic mid_low   = (r.tick == 10'(`QBX_QTR_CYC));
  wire logic sda_in    = r.sda_s[1];

  // Sequencer: one phase per half period of SCL
  always_comb begin
    next_r          = r;
    next_r.done     = 1'b0;
    next_r.scl_s    = {r.scl_s[0], scl_line};
    next_r.sda_s    = {r.sda_s[0], sda_line};
    next_r.irq_s    = {r.irq_s[0], irq_n};
    // Reported only; the expander clears its own line when we read or write it
    next_r.irq_pend = ~r.irq_s[1];
    next_r.tick     = half_done ? 10'h000 : r.tick + 10'h001;
    unique case (r.state)
      QBX_IDLE: begin
        next_r.tick   = 10'h000;
        next_r.scl_oe = 1'b0;
        next_r.sda_oe = 1'b0;
        if (req) begin
          // Selects are latched here into the address byte; wdata is taken later, at the address ack
          next_r.shreg  = addr_byte(addr_select, req_read);
          next_r.dir    = req_read;
          next_r.busy   = 1'b1;
          next_r.nack   = 1'b0;
          next_r.phase  = QBX_PH_ADDR;
          next_r.sda_oe = 1'b1;
          next_r.state  = QBX_START;
        end
      end
      QBX_START: if (half_done) begin
        next_r.scl_oe = 1'b1;
        next_r.bitn   = 3'h7;
        next_r.state  = QBX_BIT_LO;
      end
      QBX_BIT_LO: begin
        // Drive data while SCL low; release during reads
        if (mid_low) begin
          next_r.sda_oe = (r.phase == QBX_PH_RDATA) ? 1'b0 : ~r.shreg[7];
        end
        if (half_done) begin
          next_r.scl_oe = 1'b0;
          next_r.state  = QBX_BIT_HI;
        end
      end
      QBX_BIT_HI: if (half_done && r.scl_s[1]) begin
        next_r.shreg  = {r.shreg[6:0], sda_in};
        next_r.scl_oe = 1'b1;
        if (r.bitn == 3'h0) begin
          next_r.state = QBX_ACK_LO;
        end else begin
          next_r.bitn  = r.bitn - 3'h1;
          next_r.state = QBX_BIT_LO;
        end
      end
      QBX_ACK_LO: begin
        // Controller acks nothing: a read byte is the last, so it is not acked
        if (mid_low) begin
          next_r.sda_oe = 1'b0;
        end
        if (half_done) begin
          next_r.scl_oe = 1'b0;
          next_r.state  = QBX_ACK_HI;
        end
      end
      QBX_ACK_HI: if (half_done && r.scl_s[1]) begin
        next_r.scl_oe = 1'b1;
        if (r.phase == QBX_PH_ADDR) begin
          if (sda_in) begin
            next_r.nack  = 1'b1;
            next_r.state = QBX_STOP_LO;
          end else begin
            next_r.phase = r.dir ? QBX_PH_RDATA : QBX_PH_WDATA;
            next_r.shreg = wdata;
            next_r.bitn  = 3'h7;
            next_r.state = QBX_BIT_LO;
          end
        end else begin
          if (r.phase == QBX_PH_RDATA) next_r.rdata = r.shreg;
          else next_r.nack = sda_in;
          // One data byte only; further bytes would be dropped anyway
          next_r.state = QBX_STOP_LO;
        end
      end
      QBX_STOP_LO: begin
        // Pull SDA low first so that releasing it later under a high SCL is the stop
        if (mid_low) begin
          next_r.sda_oe = 1'b1;
        end
        if (half_done) begin
          next_r.scl_oe = 1'b0;
          next_r.state  = QBX_STOP_HI;
        end
      end
      QBX_STOP_HI: if (half_done && r.scl_s[1]) begin
        next_r.sda_oe = 1'b0;
        next_r.state  = QBX_STOP_END;
      end
      QBX_STOP_END: if (half_done) begin
        next_r.busy  = 1'b0;
        next_r.done  = 1'b1;
        next_r.state = QBX_IDLE;
      end
      default: next_r.state = QBX_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      r        <= '0;
      r.state  <= QBX_IDLE;
      r.phase  <= QBX_PH_ADDR;
      r.scl_s  <= 2'h3;
      r.sda_s  <= 2'h3;
      r.irq_s  <= 2'h3;
      r.rdata  <= `QBX_PORT_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign busy        = r.busy;
  assign done        = r.done;
  assign nack        = r.nack;
  assign rdata       = r.rdata;
  assign scl_oe      = r.scl_oe;
  assign sda_oe      = r.sda_oe;
  assign irq_pending = r.irq_pend;

  // Checks
  a_start_cond: assert property (@(posedge clk) disable iff (srst)
    (r.state == QBX_IDLE && req) |=> r.sda_oe && !r.scl_oe)
    else $error("start not issued");
  a_stop_cond: assert property (@(posedge clk) disable iff (srst)
    (r.state == QBX_STOP_HI && next_r.state == QBX_STOP_END) |=> !r.sda_oe && !r.scl_oe)
    else $error("stop not issued");
  a_addr_byte: assert property (@(posedge clk) disable iff (srst)
    (r.state == QBX_IDLE && req) |=> r.shreg[7:4] == 4'h4)
    else $error("bad address nibble");
  a_sda_stable: assert property (@(posedge clk) disable iff (srst)
    (r.state == QBX_BIT_HI || r.state == QBX_ACK_HI) |-> $stable(r.sda_oe))
    else $error("sda moved while scl high");
  a_nack_stop: assert property (@(posedge clk) disable iff (srst)
    (r.state == QBX_ACK_HI && r.phase == QBX_PH_ADDR && next_r.nack)
      |=> r.state == QBX_STOP_LO)
    else $error("nack not followed by stop");
  a_single_byte: assert property (@(posedge clk) disable iff (srst)
    (r.state == QBX_ACK_HI && r.phase != QBX_PH_ADDR && half_done && r.scl_s[1])
      |=> r.state == QBX_STOP_LO)
    else $error("extra byte sent");
  a_read_release: assert property (@(posedge clk) disable iff (srst)
    (r.phase == QBX_PH_RDATA && r.state == QBX_BIT_HI) |-> !r.sda_oe)
    else $error("sda driven during read");
  a_done_pulse: assert property (@(posedge clk) disable iff (srst)
    r.done |-> !r.busy ##1 !r.done)
    else $error("done not a pulse");
  c_write: cover property (@(posedge clk) r.phase == QBX_PH_WDATA && r.done);
  c_read: cover property (@(posedge clk) r.phase == QBX_PH_RDATA && r.done);
  c_nack: cover property (@(posedge clk) r.nack && r.done);
  c_irq_busy: cover property (@(posedge clk) r.irq_pend && r.busy);
endmodule // qbx_ctrl
`default_nettype wire

// ---- sim/qbx_ctrl_bench.sv ----
// Self-checking bench for the port expander controller
`timescale 1ns/1ps
`default_nettype none
module qbx_ctrl_bench;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       req = 1'b0;
  logic       req_read = 1'b0;
  logic [2:0] asel = 3'h3;
  logic [7:0] wdata = 8'h00;
  logic [7:0] ext_n = 8'hFF;
  logic       busy, done, nack, irq_pending, scl_oe, sda_oe, pull, irq_n;
  logic [7:0] rdata, pins;
  int         bad_count = 0;
  int         checks_done = 0;
  // Open-drain lines with board pull-ups
  wire        scl = ~scl_oe;
  wire        sda = ~(sda_oe | pull);
  initial forever #2.5 clk = ~clk;
  qbx_ctrl uut (.clk(clk), .srst(srst), .req(req), .req_read(req_read), .addr_select(asel),
    .wdata(wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata),
    .irq_pending(irq_pending), .scl_line(scl), .scl_oe(scl_oe), .sda_line(sda),
    .sda_oe(sda_oe), .irq_n(irq_n));
  qbx_dev_model dev (.scl(scl), .sda(sda), .sda_pull(pull), .strap(3'h3), .ext_n(ext_n),
    .pins(pins), .irq_n(irq_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One whole transfer; straps and data held until the next one
  task automatic xfer(input logic rd, input logic [2:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    req <= 1'b1;
    req_read <= rd;
    asel <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    #1;
    check({6'h00, busy, sda_oe}, 8'h03);
    for (i = 0; i < 40000 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      bad_count++;
      summarize();
    end
    check({6'h00, busy, sda_oe}, 8'h00);
  endtask
  // Move the outside drivers and let the interrupt settle
  task automatic drive_ext(input logic [7:0] v);
    @(posedge clk);
    ext_n <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check(rdata, 8'hFF);
    check(pins, 8'hFF);
    check({7'h0, busy}, 8'h00);
    $display("test reset done");
    xfer(1'b0, 3'h3, 8'h5A);
    check({7'h0, nack}, 8'h00);
    check(pins, 8'h5A);
    $display("test write done");
    // Two released pins pulled low from outside
    drive_ext(8'hF0);
    check({7'h0, irq_pending}, 8'h01);
    xfer(1'b1, 3'h3, 8'h00);
    check(rdata, 8'h50);
    check({7'h0, irq_pending}, 8'h00);
    $display("test read done");
    // Another address must be refused and leave the interrupt set
    drive_ext(8'hFF);
    check({7'h0, irq_pending}, 8'h01);
    xfer(1'b0, 3'h5, 8'h00);
    check({7'h0, nack}, 8'h01);
    check(pins, 8'h5A);
    check({7'h0, irq_pending}, 8'h01);
    $display("test foreign address done");
    summarize();
  end
endmodule // qbx_ctrl_bench
`default_nettype wire

// ---- sim/qbx_dev_model.sv ----
// Behavioural port expander that answers the controller on the I2C lines
`timescale 1ns/1ps
`default_nettype none
module qbx_dev_model (
  // Resolved bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  output var  logic       sda_pull,
  // Straps and port
  input  wire logic [2:0] strap,
  input  wire logic [7:0] ext_n,
  output var  logic [7:0] pins,
  output var  logic       irq_n
);
  logic [7:0] latch = 8'hFF;
  logic [7:0] snap  = 8'hFF;
  logic [7:0] sh    = 8'h00;
  logic [7:0] rd    = 8'hFF;
  int         c     = 0;
  logic       act   = 1'b0;
  logic       sel   = 1'b0;
  logic       rw    = 1'b0;
  initial sda_pull = 1'b0;
  // A pin reads low if the latch or the outside world pulls it
  assign pins  = latch & ext_n;
  // Any difference from the pin value seen at the last read or write pulls the line low
  assign irq_n = (pins == snap);
  // Start and stop framing
  always @(negedge sda) if (scl) begin
    c = 0;
    act = 1'b1;
    sel = 1'b0;
  end
  // Stop drops a partial byte, the latch keeps the last acked value
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sda_pull = 1'b0;
  end
  // Sample on rising SCL, bit 7 first
  always @(posedge scl) if (act) begin
    c = c + 1;
    if (c <= 8 || (c >= 10 && c <= 17)) sh = {sh[6:0], sda};
    if (c == 8) begin
      rw = sda;
      sel = (sh[7:1] == {4'h4, strap});
    end
    if (sel && rw && c == 9) begin
      rd = pins;
      snap = pins;
    end
    if (sel && !rw && c == 18) begin
      latch = sh;
      snap = sh & ext_n;
    end
  end
  // Drive on falling SCL; later bytes get no answer
  always @(negedge scl) if (act) begin
    sda_pull = sel && (c == 8 || (!rw && c == 17) ||
      (rw && c >= 9 && c <= 16 && !rd[16 - c]));
  end
endmodule // qbx_dev_model
`default_nettype wire
